// ===== design/ccr_regs.sv
// Purpose: program registers of a stereo codec, written over a three-wire serial port
// Assumes: clk_sys far faster than control and bit clocks; all pins asynchronous
// Notes: the host writes; nothing is read back
//   reserved bit positions are never stored, so stray host bits cannot leak into a mode
//   zero detection counts bit clock rises of the dac data pin, enabled or not
`include "ccr_consts.svh"

module ccr_regs #(
  parameter int ZERO_RUN_BCK = `CCR_ZERO_RUN_BCK // zero bits before the amplifier is cut
) (
  // clock and reset
  input wire logic clk_sys, // system clock, 250 MHz
  input wire logic rst, // async reset, active high
  // three-wire control port
  input wire logic control_clock, // serial control clock pin
  input wire logic control_serial_data, // serial control data pin
  input wire logic control_latch, // serial control latch pin
  // audio clock and data pins
  input wire logic bit_clock_in, // audio bit clock pin
  input wire logic word_clock_in, // audio word clock pin
  input wire logic dac_serial_in, // audio data pin toward the dac
  // adc core side, already on clk_sys
  input wire logic adc_serial_raw, // adc core serial data, clk_sys domain
  output logic adc_serial_out, // adc serial data toward the pin
  // attenuation toward the dac filter
  output logic [7:0] dac_left_level, // applied left attenuation
  output logic [7:0] dac_right_level, // applied right attenuation
  // converter control
  output logic adc_sleep, // adc section stopped
  output logic dac_sleep, // dac section stopped, outputs grounded
  output logic highpass_skip, // adc highpass bypassed
  output logic dac_force_bpz, // dac outputs at half supply
  output logic amp_disconnect, // output amplifier cut after zero run
  output ccr_pkg::ccr_emph_e emphasis_select, // de-emphasis mode
  output logic soft_silence, // filter mute of both channels
  // format, framing and write pulse
  output logic adc_to_dac_loop, // dac fed from adc
  output ccr_pkg::ccr_fmt_e audio_format_select, // audio format
  output ccr_pkg::ccr_just_e dac_justify, // dac serial justification
  output ccr_pkg::ccr_just_e adc_justify, // adc serial justification
  output logic word_bits_20, // 20-bit words, else 16
  output logic word_clock_polarity, // word clock polarity bit
  output logic left_channel_now, // current word is the left one
  output logic word_written // pulse: a word was latched
);

  // counter wide enough to hold the full run without wrapping
  localparam int ZW = $clog2(ZERO_RUN_BCK + 1);
  // count at which the run is long enough to cut the amplifier
  localparam logic [ZW-1:0] ZMAX = ZW'(ZERO_RUN_BCK);

  // refuse a zero-length run, which would cut the amplifier at once
  generate
    if (ZERO_RUN_BCK < 1)
    begin : g_bad
      $error("ZERO_RUN_BCK must be at least one");
    end
  endgenerate

  // whole state of the block
  // one packed word, so reset image and next value are single assignments
  typedef struct packed {
    // edge detectors on the synchronised pins
    logic cc_prev; // last control clock level
    logic cl_prev; // last latch level
    logic bck_prev; // last bit clock level
    // serial capture
    logic [`CCR_WORD_W-1:0] shift; // incoming serial word
    // attenuation: written and applied values
    logic [7:0] left_pend; // written left value
    logic [7:0] right_pend; // written right value
    logic [7:0] left_lvl; // applied left value
    logic [7:0] right_lvl; // applied right value
    // converter control fields
    logic adc_sleep; // adc power down
    logic hp_skip; // highpass bypass
    logic dac_sleep; // dac power down
    logic common; // common level mode
    logic zrun_en; // zero run mute enable
    logic force_bpz; // force bipolar zero
    logic [1:0] emph; // de-emphasis code
    logic silence; // soft mute
    // format and loopback fields
    logic loop; // adc to dac loopback
    logic [1:0] fmt; // format code
    logic pol; // word clock polarity
    // zero run detector
    logic [ZW-1:0] zcount; // consecutive zero bits
    // registered copies that drive the ports
    logic [7:0] out_left; // registered left level
    logic [7:0] out_right; // registered right level
    logic adc_dout; // registered adc data
    logic amp_off; // registered amplifier cut
    logic left_now; // registered channel flag
    logic strobe; // registered write pulse
    logic [1:0] dac_just; // registered dac justification
    logic [1:0] adc_just; // registered adc justification
    logic bits20; // registered word length flag
  } ccr_state_s;

  // reset image: every field at its default
  localparam ccr_state_s ST_RST = '{
    left_pend: `CCR_LEVEL_RST,
    right_pend: `CCR_LEVEL_RST,
    left_lvl: `CCR_LEVEL_RST,
    right_lvl: `CCR_LEVEL_RST,
    out_left: `CCR_LEVEL_RST,
    out_right: `CCR_LEVEL_RST,
    emph: `CCR_EMPH_RST,
    fmt: `CCR_FMT_RST,
    adc_just: ccr_pkg::CCR_JUST_LEFT,
    default: '0
  };

  ccr_state_s st_r;
  ccr_state_s st_nxt;
  // bundle order is fixed by the pin index macros
  logic [`CCR_PIN_N-1:0] pin_raw; // raw pin bundle
  logic [`CCR_PIN_N-1:0] pin_s; // synchronised pin bundle
  logic [`CCR_WORD_W-1:0] word; // word taken at the latch
  logic [1:0] sel; // register select of that word

  // i2s framing: format three, or loopback, which forces it on the dac side
  function automatic logic uses_i2s(input logic [1:0] fmt, input logic loop);
    return (fmt == `CCR_FMT_I2S) || loop;
  endfunction : uses_i2s

  // dac justification; loopback forces i2s on the dac side
  function automatic ccr_pkg::ccr_just_e dac_just_of(input logic [1:0] fmt, input logic loop);
    ccr_pkg::ccr_just_e j;
    j = ccr_pkg::CCR_JUST_RIGHT;
    if (uses_i2s(fmt, loop))
    begin
      j = ccr_pkg::CCR_JUST_I2S;
    end
    else if (fmt == `CCR_FMT_LJ)
    begin
      j = ccr_pkg::CCR_JUST_LEFT;
    end
    return j;
  endfunction : dac_just_of

  // adc justification: left unless i2s
  function automatic ccr_pkg::ccr_just_e adc_just_of(input logic [1:0] fmt);
    ccr_pkg::ccr_just_e j;
    j = ccr_pkg::CCR_JUST_LEFT;
    if (fmt == `CCR_FMT_I2S)
    begin
      j = ccr_pkg::CCR_JUST_I2S;
    end
    return j;
  endfunction : adc_just_of

  assign pin_raw = {dac_serial_in, word_clock_in, bit_clock_in,
                    control_latch, control_serial_data, control_clock};

  // every pin from outside crosses by three flip-flops
  // the agreement stage costs a cycle of latency but rejects one-sample glitches
  ccr_pin_sync #(
    .WIDTH(`CCR_PIN_N)
  ) u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .pin_raw(pin_raw),
    .pin_stable(pin_s)
  );

  // the word is whatever sits in the shifter when the latch rise is seen
  assign word = st_r.shift;
  // select bits pick the register; reserved bits above them are never read
  assign sel = word[`CCR_SEL_HI:`CCR_SEL_LO];

  // next state: serial capture, register decode, zero run and outputs
  always_comb
  begin
    st_nxt = st_r;
    // edge detectors follow the synchronised pins every cycle
    st_nxt.cc_prev = pin_s[`CCR_PIN_CC];
    st_nxt.cl_prev = pin_s[`CCR_PIN_CL];
    st_nxt.bck_prev = pin_s[`CCR_PIN_BCK];
    // the write pulse lasts one cycle unless another latch edge arrives
    st_nxt.strobe = 1'b0;

    // shift data msb first on each control clock rise
    // extra rises push older bits out, so only the last sixteen count
    if (pin_s[`CCR_PIN_CC] && !st_r.cc_prev)
    begin
      st_nxt.shift = {st_r.shift[`CCR_WORD_W-2:0], pin_s[`CCR_PIN_CD]};
    end

    // latch rise commits the last sixteen bits; reserved bits never stored
    if (pin_s[`CCR_PIN_CL] && !st_r.cl_prev)
    begin
      st_nxt.strobe = 1'b1;
      // every select code names a register, so no default is needed
      unique case (sel)
        // left word: keep the value, apply it only with the load bit
        `CCR_SEL_LEFT:
        begin
          st_nxt.left_pend = word[`CCR_LEVEL_HI:0];
          if (word[`CCR_LOAD_BIT])
          begin
            // both levels move together so the image stays balanced
            st_nxt.left_lvl = word[`CCR_LEVEL_HI:0];
            st_nxt.right_lvl = st_r.right_pend;
          end
        end
        // right word: mirror image of the left branch
        `CCR_SEL_RIGHT:
        begin
          st_nxt.right_pend = word[`CCR_LEVEL_HI:0];
          if (word[`CCR_LOAD_BIT])
          begin
            st_nxt.right_lvl = word[`CCR_LEVEL_HI:0];
            // the pending left value joins the new right one
            st_nxt.left_lvl = st_r.left_pend;
          end
        end
        // converter control: every field takes effect at once
        `CCR_SEL_CTRL:
        begin
          st_nxt.adc_sleep = word[`CCR_ADC_SLEEP_BIT];
          st_nxt.hp_skip = word[`CCR_HP_SKIP_BIT];
          st_nxt.dac_sleep = word[`CCR_DAC_SLEEP_BIT];
          st_nxt.common = word[`CCR_COMMON_BIT];
          st_nxt.zrun_en = word[`CCR_ZRUN_EN_BIT];
          st_nxt.force_bpz = word[`CCR_FORCE_BIT];
          st_nxt.emph = word[`CCR_EMPH_HI:`CCR_EMPH_LO];
          st_nxt.silence = word[`CCR_SILENCE_BIT];
        end
        `CCR_SEL_FMT:
        begin
          // only the three defined fields are kept
          st_nxt.loop = word[`CCR_LOOP_BIT];
          st_nxt.fmt = word[`CCR_FMT_HI:`CCR_FMT_LO];
          st_nxt.pol = word[`CCR_POL_BIT];
        end
      endcase
    end

    // count consecutive zero data bits on each bit clock rise, saturating
    // saturation keeps a long silence from wrapping back to a short run
    if (pin_s[`CCR_PIN_BCK] && !st_r.bck_prev)
    begin
      // a one sample restarts the run
      if (pin_s[`CCR_PIN_DIN])
      begin
        st_nxt.zcount = '0;
      end
      else if (st_r.zcount != ZMAX)
      begin
        st_nxt.zcount = st_r.zcount + ZW'(1);
      end
    end
    // the count keeps running while disabled so enabling acts at once
    st_nxt.amp_off = st_nxt.zrun_en && (st_nxt.zcount == ZMAX);

    // applied levels; common mode ignores the right register
    // the right register still records writes, so leaving common mode restores it
    st_nxt.out_left = st_nxt.left_lvl;
    st_nxt.out_right = st_nxt.common ? st_nxt.left_lvl : st_nxt.right_lvl;

    // sleeping adc sends zeros, dac side untouched
    // core data is on clk_sys already, so it is only retimed, never synchronised
    st_nxt.adc_dout = st_nxt.adc_sleep ? 1'b0 : adc_serial_raw;

    // i2s puts left on the low half; other formats honour the polarity bit
    // the flag trails the word clock pin by the synchroniser delay
    if (uses_i2s(st_nxt.fmt, st_nxt.loop))
    begin
      st_nxt.left_now = !pin_s[`CCR_PIN_WCK];
    end
    else
    begin
      st_nxt.left_now = pin_s[`CCR_PIN_WCK] ^ st_nxt.pol;
    end

    // decodes ride with the format fields, so every data port comes from a flip-flop
    st_nxt.dac_just = dac_just_of(st_nxt.fmt, st_nxt.loop);
    st_nxt.adc_just = adc_just_of(st_nxt.fmt);
    st_nxt.bits20 = (st_nxt.fmt != `CCR_FMT_RST);
  end

  // register the state; reset takes the default image
  // one register for the whole state keeps every output aligned to one edge
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      // the synchroniser clears too, so pins resting high need a few cycles to show
      st_r <= ST_RST;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from the state register
  assign adc_serial_out = st_r.adc_dout;
  // levels move only on a load, or when common mode is switched
  assign dac_left_level = st_r.out_left;
  assign dac_right_level = st_r.out_right;
  assign adc_sleep = st_r.adc_sleep;
  assign dac_sleep = st_r.dac_sleep;
  assign highpass_skip = st_r.hp_skip;
  assign dac_force_bpz = st_r.force_bpz;
  assign amp_disconnect = st_r.amp_off;
  assign emphasis_select = ccr_pkg::ccr_emph_e'(st_r.emph);
  assign soft_silence = st_r.silence;
  assign adc_to_dac_loop = st_r.loop;
  assign audio_format_select = ccr_pkg::ccr_fmt_e'(st_r.fmt);
  // decoded framing, registered with the fields it follows
  assign dac_justify = ccr_pkg::ccr_just_e'(st_r.dac_just);
  assign adc_justify = ccr_pkg::ccr_just_e'(st_r.adc_just);
  assign word_bits_20 = st_r.bits20;
  assign word_clock_polarity = st_r.pol;
  assign left_channel_now = st_r.left_now;
  assign word_written = st_r.strobe;

endmodule : ccr_regs

// ===== design/ccr_consts.svh
// Purpose: named bit positions, codes and reset values for the codec control registers
// Assumes: included by bare name from the design files
// Notes: definitions only
`ifndef CCR_CONSTS_SVH
`define CCR_CONSTS_SVH

// serial word and register select
`define CCR_WORD_W 16
`define CCR_SEL_HI 10
`define CCR_SEL_LO 9
`define CCR_SEL_LEFT 2'h0
`define CCR_SEL_RIGHT 2'h1
`define CCR_SEL_CTRL 2'h2
`define CCR_SEL_FMT 2'h3

// attenuation words
`define CCR_LOAD_BIT 8
`define CCR_LEVEL_HI 7
`define CCR_LEVEL_RST 8'hFF

// converter control word
`define CCR_ADC_SLEEP_BIT 8
`define CCR_HP_SKIP_BIT 7
`define CCR_DAC_SLEEP_BIT 6
`define CCR_COMMON_BIT 5
`define CCR_ZRUN_EN_BIT 4
`define CCR_FORCE_BIT 3
`define CCR_EMPH_HI 2
`define CCR_EMPH_LO 1
`define CCR_SILENCE_BIT 0
`define CCR_EMPH_RST 2'h1

// format and loopback word
`define CCR_LOOP_BIT 5
`define CCR_FMT_HI 3
`define CCR_FMT_LO 2
`define CCR_POL_BIT 1
`define CCR_FMT_RST 2'h0
`define CCR_FMT_LJ 2'h2
`define CCR_FMT_I2S 2'h3
`define CCR_FLAG_RST 1'h0

// zero run length in bit clock cycles
`define CCR_ZERO_RUN_BCK 65536

// pin order inside the synchroniser bundle
`define CCR_PIN_CC 0
`define CCR_PIN_CD 1
`define CCR_PIN_CL 2
`define CCR_PIN_BCK 3
`define CCR_PIN_WCK 4
`define CCR_PIN_DIN 5
`define CCR_PIN_N 6

`endif

// ===== design/ccr_pkg.sv
// Purpose: shared types of the codec control register block
// Assumes: codes follow declaration order
// Notes: used by scoped name only
package ccr_pkg;

  // de-emphasis modes, in field code order
  typedef enum logic [1:0] {
    CCR_EMPH_44K1,
    CCR_EMPH_OFF,
    CCR_EMPH_48K,
    CCR_EMPH_32K
  } ccr_emph_e;

  // audio data formats, in field code order
  typedef enum logic [1:0] {
    CCR_FMT_16_RJ,
    CCR_FMT_20_RJ,
    CCR_FMT_20_LJ,
    CCR_FMT_20_I2S
  } ccr_fmt_e;

  // serial justification of one converter
  typedef enum logic [1:0] {
    CCR_JUST_RIGHT,
    CCR_JUST_LEFT,
    CCR_JUST_I2S
  } ccr_just_e;

endpackage : ccr_pkg

// ===== design/ccr_pin_sync.sv
// Purpose: three-stage synchroniser for a bundle of asynchronous pins
// Assumes: pins are quasi-static against clk_sys
// Notes: an output only moves when stages two and three agree
module ccr_pin_sync #(
  parameter int WIDTH = 6
) (
  input wire logic clk_sys, // system clock
  input wire logic rst, // async reset, active high
  input wire logic [WIDTH-1:0] pin_raw, // raw pin levels
  output logic [WIDTH-1:0] pin_stable // filtered levels
);

  generate
    if (WIDTH < 1)
    begin : g_bad
      $error("ccr_pin_sync needs at least one pin");
    end
  endgenerate

  // whole state of the synchroniser
  typedef struct packed {
    logic [WIDTH-1:0] meta; // first stage, read only by the second
    logic [WIDTH-1:0] mid; // second stage
    logic [WIDTH-1:0] late; // third stage
    logic [WIDTH-1:0] held; // agreed level
  } ccr_sync_s;

  ccr_sync_s st_r;
  ccr_sync_s st_nxt;

  // shift the stages; each bit accepts a change once two and three agree
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.meta = pin_raw;
    st_nxt.mid = st_r.meta;
    st_nxt.late = st_r.mid;
    for (int i = 0; i < WIDTH; i++)
    begin
      if (st_r.mid[i] == st_r.late[i])
      begin
        st_nxt.held[i] = st_r.late[i];
      end
    end
  end

  // register the state
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign pin_stable = st_r.held;

endmodule : ccr_pin_sync

// ===== tb/ccr_regs_sva.sv
// Purpose: concurrent checks on the ports of the codec control register block
// Assumes: one clock domain, asynchronous active-high reset
// Notes: bound to every ccr_regs instance by the statement after endmodule
module ccr_regs_sva #(
  parameter int ZERO_RUN_BCK = 16 // zero run length, handed on by the bind
) (
  input wire logic clk_sys, // system clock
  input wire logic rst, // async reset, active high
  input wire logic control_latch, // latch pin
  input wire logic dac_serial_in, // dac audio data pin
  input wire logic adc_serial_raw, // adc core data
  input wire logic adc_serial_out, // adc data toward the pin
  input wire logic [7:0] dac_left_level, // applied left level
  input wire logic [7:0] dac_right_level, // applied right level
  input wire logic adc_sleep, // adc stopped
  input wire logic dac_sleep, // dac stopped
  input wire logic amp_disconnect, // amplifier cut
  input wire logic adc_to_dac_loop, // loopback active
  input wire ccr_pkg::ccr_fmt_e audio_format_select, // audio format
  input wire ccr_pkg::ccr_just_e dac_justify, // dac justification
  input wire ccr_pkg::ccr_just_e adc_justify, // adc justification
  input wire logic word_bits_20, // 20-bit words
  input wire logic word_written // commit pulse
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // the latch edge on the pin, then the commit a few cycles on
  sequence s_latch_rise;
    $rose(control_latch);
  endsequence
  sequence s_commit;
    ##[2:8] word_written;
  endsequence

  a_commit_after_latch: assert property (s_latch_rise |-> s_commit)
    else $error("no word committed after a latch rise");
  a_commit_needs_latch: assert property (word_written |-> control_latch)
    else $error("word committed without the latch high");
  a_commit_pulse_once: assert property (word_written |=> !word_written)
    else $error("commit pulse longer than one cycle");
  // levels may only move in the cycle a word lands
  a_levels_on_write: assert property (($changed(dac_left_level) || $changed(dac_right_level)) |-> word_written)
    else $error("level moved without a written word");
  a_modes_on_write: assert property (($changed(adc_sleep) || $changed(dac_sleep) || $changed(adc_to_dac_loop))
    |-> word_written)
    else $error("mode flag moved without a written word");
  // two-cycle window: the gate may use the flag of either cycle
  a_adc_held_zero: assert property (adc_sleep && $past(adc_sleep) |-> !adc_serial_out)
    else $error("adc data not held at zero while asleep");
  a_adc_passes: assert property (!adc_sleep && !$past(adc_sleep) && !$past(rst)
    |-> adc_serial_out == $past(adc_serial_raw))
    else $error("adc data not passed while awake");
  a_i2s_both: assert property (audio_format_select == ccr_pkg::CCR_FMT_20_I2S
    |-> adc_justify == ccr_pkg::CCR_JUST_I2S && dac_justify == ccr_pkg::CCR_JUST_I2S)
    else $error("format three not i2s on both sides");
  a_loop_i2s: assert property (adc_to_dac_loop |-> dac_justify == ccr_pkg::CCR_JUST_I2S)
    else $error("loopback without i2s on the dac");
  a_bits20_map: assert property (word_bits_20 == (audio_format_select != ccr_pkg::CCR_FMT_16_RJ))
    else $error("word length disagrees with format");
  a_amp_after_zeros: assert property ($rose(amp_disconnect)
    |-> $past(dac_serial_in, 4) == 1'b0 && $past(dac_serial_in, 8) == 1'b0)
    else $error("amplifier cut while data was not zero");
endmodule : ccr_regs_sva

bind ccr_regs ccr_regs_sva #(.ZERO_RUN_BCK(ZERO_RUN_BCK)) i_sva (
  .clk_sys(clk_sys), .rst(rst), .control_latch(control_latch), .dac_serial_in(dac_serial_in),
  .adc_serial_raw(adc_serial_raw), .adc_serial_out(adc_serial_out), .dac_left_level(dac_left_level),
  .dac_right_level(dac_right_level), .adc_sleep(adc_sleep), .dac_sleep(dac_sleep),
  .amp_disconnect(amp_disconnect), .adc_to_dac_loop(adc_to_dac_loop),
  .audio_format_select(audio_format_select), .dac_justify(dac_justify), .adc_justify(adc_justify),
  .word_bits_20(word_bits_20), .word_written(word_written)
);

// ===== tb/ccr_host_model.sv
// Purpose: host side of the three-wire control port
// Assumes: a 64 ns control clock paced by whole clk_sys ticks
// Notes: the clock idles low between words; data shows the inverse of its last bit after a word
module ccr_host_model (
  input wire logic clk_sys, // system clock, only paces the pins
  output logic control_clock, // serial clock pin
  output logic control_serial_data, // serial data pin
  output logic control_latch // latch pin
);
  timeunit 1ns;
  timeprecision 100ps;

  // pins low at reset release, as the port expects
  initial
  begin
    control_clock = 1'b0;
    control_serial_data = 1'b0;
    control_latch = 1'b0;
  end

  // whole system clocks, then the common small skew
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick

  // reserved bits arrive as the caller gives them; only refusal tests set them
  task automatic send_word(input logic [15:0] w);
    for (int i = 15; i >= 0; i--)
    begin
      control_serial_data = w[i]; // msb first
      tick(8);
      control_clock = 1'b1;
      tick(8);
      control_clock = 1'b0;
    end
    control_serial_data = ~w[0]; // no stale bit left on the line
    control_latch = 1'b1; // commit after the sixteenth rise
    tick(16);
    control_latch = 1'b0;
    tick(8);
  endtask : send_word
endmodule : ccr_host_model

// ===== tb/tb_top.sv
// Purpose: self-checking bench for the codec control registers
// Assumes: zero run shortened to 16 bit clocks
// Notes: words go through the host model; outputs sampled 1 ns after the rising clock edge
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk_sys, rst, bit_clock_in, word_clock_in, dac_serial_in, adc_serial_raw;
  logic control_clock, control_serial_data, control_latch;
  logic adc_serial_out, adc_sleep, dac_sleep, highpass_skip, dac_force_bpz, amp_disconnect, soft_silence;
  logic adc_to_dac_loop, word_bits_20, word_clock_polarity, left_channel_now, word_written;
  logic [7:0] dac_left_level, dac_right_level;
  ccr_pkg::ccr_emph_e emphasis_select;
  ccr_pkg::ccr_fmt_e audio_format_select;
  ccr_pkg::ccr_just_e dac_justify, adc_justify;
  logic [15:0] w; // word under test
  logic lp, pl; // loopback and polarity of the format word
  logic [15:0] ctrl_pat [4] = '{16'h0101, 16'h0088, 16'h0060, 16'h0010}; // control flags per pass
  int error_cnt = 0;
  int samples_checked = 0;

  ccr_regs #(.ZERO_RUN_BCK(16)) i_dut (
    .clk_sys(clk_sys), .rst(rst), .control_clock(control_clock), .control_serial_data(control_serial_data),
    .control_latch(control_latch), .bit_clock_in(bit_clock_in), .word_clock_in(word_clock_in),
    .dac_serial_in(dac_serial_in), .adc_serial_raw(adc_serial_raw), .adc_serial_out(adc_serial_out),
    .dac_left_level(dac_left_level), .dac_right_level(dac_right_level), .adc_sleep(adc_sleep),
    .dac_sleep(dac_sleep), .highpass_skip(highpass_skip), .dac_force_bpz(dac_force_bpz),
    .amp_disconnect(amp_disconnect), .emphasis_select(emphasis_select), .soft_silence(soft_silence),
    .adc_to_dac_loop(adc_to_dac_loop), .audio_format_select(audio_format_select), .dac_justify(dac_justify),
    .adc_justify(adc_justify), .word_bits_20(word_bits_20), .word_clock_polarity(word_clock_polarity),
    .left_channel_now(left_channel_now), .word_written(word_written)
  );

  ccr_host_model i_host (
    .clk_sys(clk_sys), .control_clock(control_clock), .control_serial_data(control_serial_data),
    .control_latch(control_latch)
  );

  // 250 MHz system clock
  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick

  // four-state compare, counted
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  // one word, waiting under a bound for its commit pulse
  task automatic wr(input logic [15:0] word);
    int n;
    n = 0;
    fork
      i_host.send_word(word);
      while (word_written !== 1'b1 && n < 2000)
      begin
        @(negedge clk_sys);
        n++;
      end
    join
    check(8'(n < 2000), 8'h01);
    tick(2);
  endtask : wr

  // bit clock at 64 ns, data changes with the falling edge; still between bursts
  task automatic bck(input int n, input logic d);
    repeat (n)
    begin
      dac_serial_in = d;
      tick(8);
      bit_clock_in = 1'b1;
      tick(8);
      bit_clock_in = 1'b0;
    end
  endtask : bck

  task automatic tally_and_finish();
    if (error_cnt == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : tally_and_finish

  // hang guard, far beyond the run of about 15 us
  initial
  begin
    #200000;
    error_cnt++;
    tally_and_finish();
  end

  initial
  begin
    rst = 1'b1;
    bit_clock_in = 1'b0;
    word_clock_in = 1'b1;
    dac_serial_in = 1'b0;
    adc_serial_raw = 1'b0;
    tick(2);
    rst = 1'b0;
    tick(4);
    // defaults after reset
    check(dac_left_level, 8'hFF);
    check(dac_right_level, 8'hFF);
    check(emphasis_select, 8'h01);
    check({adc_sleep, dac_sleep, highpass_skip, dac_force_bpz, amp_disconnect, soft_silence}, 8'h00);
    check({adc_to_dac_loop, word_clock_polarity, word_bits_20, audio_format_select}, 8'h00);
    check({dac_justify, adc_justify}, 8'h01);
    // load bit gating and simultaneous update of both channels
    wr(16'h0055);
    check(dac_left_level, 8'hFF);
    wr(16'h03AA);
    check(dac_left_level, 8'h55);
    check(dac_right_level, 8'hAA);
    wr(16'hF900); // mute value with reserved bits set
    check(dac_left_level, 8'h00);
    check(dac_right_level, 8'hAA);
    wr(16'h0133);
    check(dac_left_level, 8'h33);
    // every emphasis code, each pass with its own flags
    adc_serial_raw = 1'b1;
    for (int e = 0; e < 4; e++)
    begin
      w = 16'h0400 | ctrl_pat[e] | 16'(e << 1);
      wr(w);
      check({adc_sleep, highpass_skip, dac_sleep, dac_force_bpz, soft_silence},
        {3'h0, w[8], w[7], w[6], w[3], w[0]});
      check(emphasis_select, 8'(e));
      check(adc_serial_out, 8'(!w[8]));
      check(dac_right_level, w[5] ? 8'h33 : 8'hAA);
      if (e == 3)
      begin
        bck(15, 1'b0); // one short of the run
        check(amp_disconnect, 8'h00);
        bck(1, 1'b0);
        check(amp_disconnect, 8'h01);
        bck(1, 1'b1);
        check(amp_disconnect, 8'h00);
      end
    end
    // every format code; reserved bits set on the first pass
    for (int f = 0; f < 4; f++)
    begin
      lp = (f == 1);
      pl = (f == 2);
      wr(16'h0600 | 16'(f << 2) | {10'h0, lp, 3'h0, pl, 1'b0} | (f == 0 ? 16'hF9D1 : 16'h0000));
      check(audio_format_select, 8'(f));
      check({adc_to_dac_loop, word_clock_polarity, word_bits_20}, {5'h0, lp, pl, f != 0});
      check(adc_justify, f == 3 ? ccr_pkg::CCR_JUST_I2S : ccr_pkg::CCR_JUST_LEFT);
      check(dac_justify, (f == 3 || lp) ? ccr_pkg::CCR_JUST_I2S :
        (f == 2 ? ccr_pkg::CCR_JUST_LEFT : ccr_pkg::CCR_JUST_RIGHT));
      check(left_channel_now, (f == 3 || lp) ? 8'h00 : 8'(!pl));
      // swap the word clock half and expect the opposite channel
      word_clock_in = 1'b0;
      tick(6);
      check(left_channel_now, (f == 3 || lp) ? 8'h01 : 8'(pl));
      word_clock_in = 1'b1;
      tick(6);
    end
    tally_and_finish();
  end
endmodule : tb_top
